// file: hdl/prio_bank_hi.sv
// upper priority bank: six priority control registers, accepted-interrupt status,
// axi4-lite slave and a vector offer handshake to the cpu core
// assumes ref_clk domain only; request, code and acknowledge from same-clock logic
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_map.svh"

// Summary of operation
// RQ1 - field code 111 means priority level 7, the highest user level.
// RQ2 - code 001 is level 1; codes between map linearly to levels 2-6.
// RQ3 - a source with field 000 is never presented, whatever its flag.
// RQ4 - every implemented priority field resets to 100 (level 4).
// RQ5 - unimplemented bits read zero and ignore writes.
// RQ6 - reg 12: timer8, i2c2 master, i2c2 slave, timer7 fields.
// RQ7 - reg 13: can2 receive, ext irq4, ext irq3, timer9 fields.
// RQ8 - reg 14: only can2 event field in bits 2-0.
// RQ9 - reg 15: only dma ch5 done field in bits 6-4.
// RQ10 - reg 16: uart2 error bits 10-8, uart1 error bits 6-4.
// RQ11 - reg 17: can2 transmit, can1 transmit, dma ch7, dma ch6 fields.
// RQ12 - status bits 11-8 report new cpu level 0-15, reset zero.
// RQ13 - status bits 6-0 report vector minus eight, reset zero.
// RQ14 - traps take levels 8-15 and are never masked.
// RQ15 - level and vector fields update when the cpu accepts an interrupt.
module prio_bank_hi #(
  parameter int NSRC  = `PB_NUM_SOURCES,
  parameter int NTRAP = `PB_NUM_TRAPS
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // axi4-lite write address and data
  input  wire logic [11:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // per-source request (flag and enable) and vector codes
  input  wire logic [NSRC-1:0]          src_req,
  input  wire logic [NSRC*7-1:0]        src_code,
  input  wire logic [NTRAP-1:0]         trap_req,
  input  wire logic [NTRAP*7-1:0]       trap_code,
  // cpu side
  input  wire prio_bank_pkg::level_t    cpu_level,
  input  wire logic                     cpu_ack,
  output logic                          irq_valid,
  output prio_bank_pkg::level_t         irq_level,
  output prio_bank_pkg::vec_code_t      irq_code
);
  import prio_bank_pkg::*;

  logic [15:0] ctrl12_reg, ctrl13_reg, ctrl14_reg, ctrl15_reg, ctrl16_reg, ctrl17_reg;
  level_t      new_level_reg;
  vec_code_t   vec_code_reg;
  logic        aw_held_reg, w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  ack_state_e  ack_state_reg, ack_state_next;

  // named source fields, one per documented slot
  wire prio_t timer8_prio         = ctrl12_reg[14:12]; // RQ6
  wire prio_t i2c_ch2_master_prio = ctrl12_reg[10:8];
  wire prio_t i2c_ch2_slave_prio  = ctrl12_reg[6:4];
  wire prio_t timer7_prio         = ctrl12_reg[2:0];
  wire prio_t can2_receive_prio   = ctrl13_reg[14:12]; // RQ7
  wire prio_t ext_irq4_prio       = ctrl13_reg[10:8];
  wire prio_t ext_irq3_prio       = ctrl13_reg[6:4];
  wire prio_t timer9_prio         = ctrl13_reg[2:0];
  wire prio_t can2_event_prio     = ctrl14_reg[2:0]; // RQ8
  wire prio_t dma_ch5_done_prio   = ctrl15_reg[6:4]; // RQ9
  wire prio_t uart_ch2_error_prio = ctrl16_reg[10:8]; // RQ10
  wire prio_t uart_ch1_error_prio = ctrl16_reg[6:4];
  wire prio_t can2_transmit_prio  = ctrl17_reg[14:12]; // RQ11
  wire prio_t can1_transmit_prio  = ctrl17_reg[10:8];
  wire prio_t dma_ch7_done_prio   = ctrl17_reg[6:4];
  wire prio_t dma_ch6_done_prio   = ctrl17_reg[2:0];

  // source index 0 is timer8 ... 15 is dma ch6
  wire [47:0] all_prio = {dma_ch6_done_prio, dma_ch7_done_prio, can1_transmit_prio,
                          can2_transmit_prio, uart_ch1_error_prio, uart_ch2_error_prio,
                          dma_ch5_done_prio, can2_event_prio, timer9_prio, ext_irq3_prio,
                          ext_irq4_prio, can2_receive_prio, timer7_prio, i2c_ch2_slave_prio,
                          i2c_ch2_master_prio, timer8_prio};

  logic      win_valid;
  level_t    win_level;
  vec_code_t win_code;

  prio_pick #(.NSRC(NSRC), .NTRAP(NTRAP)) u_pick (
    .src_prio  (all_prio[NSRC*3-1:0]),
    .src_req   (src_req),
    .src_code  (src_code),
    .trap_req  (trap_req),
    .trap_code (trap_code),
    .cpu_level (cpu_level),
    .win_valid (win_valid),
    .win_level (win_level),
    .win_code  (win_code)
  );

  // write path: address and data taken in either order, then one write cycle
  wire        wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [11:0] wr_addr = {aw_addr_reg[11:2], 2'b00};
  wire [15:0] wr_bmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire        wr_hit  = (wr_addr <= `PB_OFF_STATUS);
  wire sel12 = wr_go && (wr_addr == `PB_OFF_CTRL_12);
  wire sel13 = wr_go && (wr_addr == `PB_OFF_CTRL_13);
  wire sel14 = wr_go && (wr_addr == `PB_OFF_CTRL_14);
  wire sel15 = wr_go && (wr_addr == `PB_OFF_CTRL_15);
  wire sel16 = wr_go && (wr_addr == `PB_OFF_CTRL_16);
  wire sel17 = wr_go && (wr_addr == `PB_OFF_CTRL_17);

  // merge under byte strobes and the implemented-bit mask
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] bmask, input logic [15:0] imask);
    logic [15:0] m;
    m = bmask & imask;
    merge = ((old_v & ~m) | (new_v & m)) & imask; // RQ5
  endfunction : merge

  // axi write handshake
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2; // unmapped answers slverr
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // priority registers; the status word is read only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl12_reg <= `PB_RESET_FULL; // RQ4
      ctrl13_reg <= `PB_RESET_FULL;
      ctrl14_reg <= `PB_RESET_14;
      ctrl15_reg <= `PB_RESET_15;
      ctrl16_reg <= `PB_RESET_16;
      ctrl17_reg <= `PB_RESET_FULL;
    end else begin
      if (sel12) ctrl12_reg <= merge(ctrl12_reg, w_data_reg[15:0], wr_bmask, `PB_MASK_FULL);
      if (sel13) ctrl13_reg <= merge(ctrl13_reg, w_data_reg[15:0], wr_bmask, `PB_MASK_FULL);
      if (sel14) ctrl14_reg <= merge(ctrl14_reg, w_data_reg[15:0], wr_bmask, `PB_MASK_14);
      if (sel15) ctrl15_reg <= merge(ctrl15_reg, w_data_reg[15:0], wr_bmask, `PB_MASK_15);
      if (sel16) ctrl16_reg <= merge(ctrl16_reg, w_data_reg[15:0], wr_bmask, `PB_MASK_16);
      if (sel17) ctrl17_reg <= merge(ctrl17_reg, w_data_reg[15:0], wr_bmask, `PB_MASK_FULL);
    end
  end

  // read decode
  wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
  wire [15:0] status_word = {4'h0, new_level_reg, 1'b0, vec_code_reg}; // RQ12 RQ13
  wire        rd_hit = (rd_addr <= `PB_OFF_STATUS);
  wire [15:0] rd_word = (rd_addr == `PB_OFF_CTRL_12) ? ctrl12_reg :
                        (rd_addr == `PB_OFF_CTRL_13) ? ctrl13_reg :
                        (rd_addr == `PB_OFF_CTRL_14) ? ctrl14_reg :
                        (rd_addr == `PB_OFF_CTRL_15) ? ctrl15_reg :
                        (rd_addr == `PB_OFF_CTRL_16) ? ctrl16_reg :
                        (rd_addr == `PB_OFF_CTRL_17) ? ctrl17_reg :
                        (rd_addr == `PB_OFF_STATUS)  ? status_word : 16'h0000;

  // axi read: one-cycle accept, data registered the next edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word}; // RQ5
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // offer state machine: the offer is frozen while waiting so the cpu sees a stable vector
  always_comb begin
    ack_state_next = ack_state_reg;
    case (ack_state_reg)
      ST_IDLE:  if (win_valid) ack_state_next = ST_OFFER;
      ST_OFFER: if (cpu_ack) ack_state_next = ST_TAKEN;
      ST_TAKEN: ack_state_next = ST_IDLE;
      default:  ack_state_next = ST_IDLE;
    endcase
  end

  // offer registers and status capture on acceptance
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_state_reg <= ST_IDLE;
      irq_valid     <= 1'b0;
      irq_level     <= 4'h0;
      irq_code      <= 7'h00;
      new_level_reg <= 4'h0; // RQ12
      vec_code_reg  <= 7'h00; // RQ13
    end else begin
      ack_state_reg <= ack_state_next;
      if (ack_state_reg == ST_IDLE && win_valid) begin
        irq_valid <= 1'b1;
        irq_level <= win_level;
        irq_code  <= win_code;
      end
      if (ack_state_reg == ST_OFFER && cpu_ack) begin
        irq_valid     <= 1'b0;
        new_level_reg <= irq_level; // RQ15
        vec_code_reg  <= irq_code;
      end
    end
  end

  // a priority-0 source alone never raises an offer
  src_zero_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ3
    (trap_req == '0 && ((src_req & 16'h0001) == src_req) && timer8_prio == 3'h0 &&
     ack_state_reg == ST_IDLE) |=> !irq_valid)
    else $error("zero priority source offered");

  fields_reset_a: assert property (@(posedge ref_clk) // RQ4
    $past(sys_rst) |-> (ctrl12_reg == 16'h4444 && ctrl14_reg == 16'h0004 &&
                        ctrl15_reg == 16'h0040 && ctrl16_reg == 16'h0440))
    else $error("priority fields not at reset value");

  unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ5
    s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[15] == 1'b0))
    else $error("unimplemented read bits not zero");

  status_update_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ15
    (ack_state_reg == ST_OFFER && cpu_ack) |=>
      (new_level_reg == $past(irq_level) && vec_code_reg == $past(irq_code) && !irq_valid))
    else $error("status not updated on acceptance");

  trap_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ14
    (ack_state_reg == ST_IDLE && trap_req[NTRAP-1]) |=> (irq_valid && irq_level == 4'hf))
    else $error("top trap not offered at level 15");

  user_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ1
    (ack_state_reg == ST_IDLE && trap_req == '0 && win_valid) |=>
      (irq_level >= 4'h1 && irq_level <= 4'h7 && irq_level > $past(cpu_level)))
    else $error("user level out of range");

  offer_held_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ2
    (irq_valid && !cpu_ack) |=> (irq_valid && $stable(irq_level) && $stable(irq_code)))
    else $error("offer changed before acceptance");

  reg14_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ8
    ctrl14_reg[15:3] == 13'h0000 && ctrl15_reg[3:0] == 4'h0 && ctrl16_reg[3:0] == 4'h0)
    else $error("unimplemented register bits set");

endmodule : prio_bank_hi
`default_nettype wire

// file: hdl/prio_pick.sv
// combinational winner search over user sources and traps
// assumes all inputs on the ref_clk domain; no registers inside
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
  parameter int NSRC = 16,
  parameter int NTRAP = 8
) (
  // user sources
  input  wire logic [NSRC*3-1:0]       src_prio,
  input  wire logic [NSRC-1:0]         src_req,
  input  wire logic [NSRC*7-1:0]       src_code,
  // traps, index i is level 8+i
  input  wire logic [NTRAP-1:0]        trap_req,
  input  wire logic [NTRAP*7-1:0]      trap_code,
  // cpu current level
  input  wire prio_bank_pkg::level_t   cpu_level,
  // winner
  output logic                         win_valid,
  output prio_bank_pkg::level_t        win_level,
  output prio_bank_pkg::vec_code_t     win_code
);
  import prio_bank_pkg::*;

  // highest level wins, lowest index breaks ties; traps are never masked
  always_comb begin
    level_t    best_l;
    vec_code_t best_c;
    logic      best_v;
    best_l = 4'h0;
    best_c = 7'h00;
    best_v = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (src_req[i] && (src_prio[i*3 +: 3] != 3'h0) &&
          ({1'b0, src_prio[i*3 +: 3]} > cpu_level) &&
          (!best_v || {1'b0, src_prio[i*3 +: 3]} > best_l)) begin // RQ3
        best_v = 1'b1;
        best_l = {1'b0, src_prio[i*3 +: 3]}; // RQ1 RQ2
        best_c = src_code[i*7 +: 7];
      end
    end
    for (int t = 0; t < NTRAP; t++) begin
      if (trap_req[t] && (!best_v || 4'(t + 8) > best_l)) begin // RQ14
        best_v = 1'b1;
        best_l = 4'(t + 8);
        best_c = trap_code[t*7 +: 7];
      end
    end
    win_valid = best_v;
    win_level = best_l;
    win_code  = best_c;
  end
endmodule : prio_pick
`default_nettype wire

// file: inc/prio_bank_map.svh
// register map, field positions and reset values of the upper priority bank
// assumes 32-bit aligned word registers on an axi4-lite slave
`ifndef PRIO_BANK_MAP_SVH
`define PRIO_BANK_MAP_SVH

`define PB_OFF_CTRL_12      12'h000
`define PB_OFF_CTRL_13      12'h004
`define PB_OFF_CTRL_14      12'h008
`define PB_OFF_CTRL_15      12'h00c
`define PB_OFF_CTRL_16      12'h010
`define PB_OFF_CTRL_17      12'h014
`define PB_OFF_STATUS       12'h018

`define PB_PRIO_RESET       3'h4
`define PB_MASK_FULL        16'h7777
`define PB_MASK_14          16'h0007
`define PB_MASK_15          16'h0070
`define PB_MASK_16          16'h0770
`define PB_RESET_FULL       16'h4444
`define PB_RESET_14         16'h0004
`define PB_RESET_15         16'h0040
`define PB_RESET_16         16'h0440

`define PB_LEVEL_LSB        8
`define PB_VECTOR_BASE      8
`define PB_NUM_SOURCES      16
`define PB_NUM_TRAPS        8

`endif

// file: inc/prio_bank_pkg.sv
// types shared by the priority bank and its arbiter
// assumes prio_bank_map.svh is on the include path
package prio_bank_pkg;
  typedef logic [2:0] prio_t;
  typedef logic [3:0] level_t;
  typedef logic [6:0] vec_code_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_OFFER = 3'b010,
    ST_TAKEN = 3'b100
  } ack_state_e;
endpackage : prio_bank_pkg

// file: tb/cpu_core_model.sv
// cpu core model: takes each offered vector after ack_delay cycles
// assumes ref_clk domain; the offer stays frozen until it is acknowledged
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // offer from the bank
  input  wire logic       irq_valid,
  input  wire logic [3:0] ack_delay,
  // acceptance
  output logic            cpu_ack,
  output int              taken_cnt
);
  logic [3:0] wait_reg;
  // one-cycle ack so a frozen offer is taken once; a long delay stands for a busy core
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cpu_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      taken_cnt <= 0;
    end else if (cpu_ack) begin
      cpu_ack   <= 1'b0;
      taken_cnt <= taken_cnt + 1;
    end else if (irq_valid && wait_reg == ack_delay) begin
      cpu_ack  <= 1'b1;
      wait_reg <= 4'h0;
    end else if (irq_valid) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// file: tb/prio_bank_hi_tb.sv
// self-checking bench of the upper priority bank: axi4-lite registers and vector offers
// assumes prio_bank_pkg compiled first and prio_bank_map.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "prio_bank_map.svh"
module prio_bank_hi_tb;
  import prio_bank_pkg::*;
  // implemented bits of ctrl 12..17, then register and lsb of each source field
  localparam logic [95:0] IMP     = 96'h7777_0770_0070_0007_7777_7777;
  localparam logic [63:0] SRC_REG = 64'h5555_4432_1111_0000;
  localparam logic [63:0] SRC_LSB = 64'h048c_4840_048c_048c;
  logic         ref_clk, sys_rst, cpu_ack, irq_valid;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]  s_axi_wdata, s_axi_rdata, status_exp;
  logic [3:0]   s_axi_wstrb, ack_delay, strb_sel;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [15:0]  src_req;
  logic [111:0] src_code;
  logic [7:0]   trap_req;
  logic [55:0]  trap_code;
  level_t       cpu_level, irq_level;
  vec_code_t    irq_code;
  logic [15:0]  shadow [6];
  int           taken_cnt, error_cnt, check_count;

  prio_bank_hi dut (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .src_req, .src_code, .trap_req, .trap_code, .cpu_level, .cpu_ack, .irq_valid,
    .irq_level, .irq_code);
  cpu_core_model cpu (.ref_clk, .sys_rst, .irq_valid, .ack_delay, .cpu_ack, .taken_cnt);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // both channels offered together, each released at its own handshake
  // waits carry no limit of their own: the watchdog ends a hung transfer
  task automatic axi_write(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= strb_sel;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_arready !== 1'b1) @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_read

  task automatic set_ctrl(input int i, input logic [31:0] dat);
    logic [1:0] r;
    axi_write(12'(i * 4), dat, r);
    check("write resp", {30'h0, r}, 32'h0);
    shadow[i] = dat[15:0] & IMP[i*16 +: 16];
  endtask : set_ctrl

  task automatic reset_check;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++) begin
      if (i < 6) shadow[i] = IMP[i*16 +: 16] & 16'h4444;
      axi_read(12'(i * 4), d, r);
      check("reset value", d, i < 6 ? {16'h0, shadow[i]} : 32'h0);
      check("read resp", {30'h0, r}, 32'h0);
    end
    status_exp = 32'h0;
  endtask : reset_check

  // expected winner as {valid, level, code}: traps first, then highest user field, lowest index
  function automatic logic [11:0] pick(input logic [15:0] req, input logic [7:0] trp, input level_t lvl);
    int         best;
    level_t     bl;
    logic [2:0] f;
    best = -1;
    bl = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (trp[i]) begin
        best = 16 + i;
        bl = 4'(8 + i);
      end
    end
    for (int i = 0; i < 16; i++) begin
      f = 3'(shadow[SRC_REG[i*4 +: 4]] >> SRC_LSB[i*4 +: 4]);
      if (best < 16 && req[i] && f != 3'h0 && {1'b0, f} > lvl && {1'b0, f} > bl) begin
        best = i;
        bl = {1'b0, f};
      end
    end
    if (best < 0) return 12'h0;
    return {1'b1, bl, best >= 16 ? trap_code[(best-16)*7 +: 7] : src_code[best*7 +: 7]};
  endfunction : pick

  // requests are dropped once offered, since the offer stays frozen until the ack
  task automatic offer(input logic [15:0] req, input logic [7:0] trp, input level_t lvl);
    logic [11:0] e;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    int          c0;
    e = pick(req, trp, lvl);
    c0 = taken_cnt;
    ack_delay <= 4'($urandom_range(15));
    src_req <= req;
    trap_req <= trp;
    cpu_level <= lvl;
    for (n = 0; n < 4 && irq_valid !== 1'b1; n++) @(posedge ref_clk);
    check("offer valid", {31'h0, irq_valid}, {31'h0, e[11]});
    if (e[11]) begin
      check("offer level", {28'h0, irq_level}, {28'h0, e[10:7]});
      check("offer code", {25'h0, irq_code}, {25'h0, e[6:0]});
      status_exp = {20'h0, e[10:7], 1'b0, e[6:0]};
    end
    src_req <= 16'h0;
    trap_req <= 8'h0;
    while (e[11] && taken_cnt == c0) @(posedge ref_clk); // a lost ack is ended by the watchdog
    repeat (3) @(posedge ref_clk);
    axi_read(`PB_OFF_STATUS, d, r);
    check("status", d, status_exp);
  endtask : offer

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {src_req, trap_req, cpu_level, ack_delay, status_exp} = '0;
    error_cnt = 0;
    check_count = 0;
    strb_sel = 4'hf;
    sys_rst = 1'b1;
    void'($urandom(37));
    src_code = 112'({$urandom, $urandom, $urandom, $urandom});
    trap_code = 56'({$urandom, $urandom});
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    reset_check();
    axi_read(12'h01c, d, r);
    check("unmapped data", d, 32'h0);
    check("unmapped resp", {30'h0, r}, 32'h2);
    axi_write(12'h01c, 32'hffff_ffff, r);
    check("unmapped wresp", {30'h0, r}, 32'h2);
    axi_write(`PB_OFF_STATUS, 32'hffff_ffff, r);
    axi_read(`PB_OFF_STATUS, d, r);
    check("status write", d, 32'h0);
    // all ones first, then random words, each read back through its mask
    for (int k = 0; k < 30; k++) begin
      set_ctrl(k % 6, k < 6 ? 32'hffff_ffff : $urandom);
      axi_read(12'((k % 6) * 4), d, r);
      check("ctrl readback", d, {16'h0, shadow[k % 6]});
    end
    // lower byte lane only: the upper lane must keep its value
    strb_sel = 4'h1;
    axi_write(`PB_OFF_CTRL_12, 32'hffff_ffff, r);
    strb_sel = 4'hf;
    shadow[0] = (shadow[0] & 16'hff00) | (16'h00ff & IMP[15:0]);
    axi_read(`PB_OFF_CTRL_12, d, r);
    check("lane write", d, {16'h0, shadow[0]});
    // every code of the timer8 field with the cpu at level 0
    for (int f = 0; f < 8; f++) begin
      set_ctrl(0, 32'(f << 12));
      offer(16'h0001, 8'h00, 4'h0);
    end
    set_ctrl(5, 32'h5555);
    offer(16'hf000, 8'h00, 4'h4);
    offer(16'hf000, 8'h00, 4'h5);
    offer(16'hffff, 8'h81, 4'hf);
    for (int t = 0; t < 60; t++) begin
      if (t % 4 == 0) set_ctrl(t % 6, $urandom);
      offer(16'($urandom), $urandom_range(5) == 0 ? 8'($urandom) : 8'h00, 4'($urandom_range(7)));
    end
    // reset in mid-run must clear the status fields again
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    reset_check();
    wrap_up();
  end
endmodule : prio_bank_hi_tb
`default_nettype wire
